//--- cfg_loader_pkg.sv
// Shared constants, field layouts and types for the port configuration loader.
`default_nettype none
package cfg_loader_pkg;

	// ==========================================
	// Sizes
	localparam int NUM_PORTS = 4;
	localparam int AXI_ADDR_W = 12;
	localparam int WORD_W = 16;

	// ==========================================
	// Memory word addresses (byte addresses, one 16-bit word per port)
	localparam logic [7:0] WORD_LINK_BASE = 8'h20;
	localparam logic [7:0] WORD_PHY2_BASE = 8'h30;
	localparam logic [7:0] WORD_PHY_BASE = 8'h40;
	localparam logic [7:0] WORD_PM_BASE = 8'h50;
	localparam logic [7:0] WORD_STRIDE = 8'h02;

	// Word groups, fetched in this order.
	localparam logic [1:0] GRP_LINK = 2'h0;
	localparam logic [1:0] GRP_PHY2 = 2'h1;
	localparam logic [1:0] GRP_PHY = 2'h2;
	localparam logic [1:0] GRP_PM = 2'h3;

	// ==========================================
	// Field positions inside a memory word
	localparam int W_FTS_LSB = 0;
	localparam int W_DESKEW_LSB = 8;
	localparam int W_SCRAM_LSB = 10;
	localparam int W_L0S_BIT = 12;
	localparam int W_SPDSEL_LSB = 13;
	localparam int W_SPDEN_BIT = 15;
	localparam int W_PHY2HI_LSB = 0;
	localparam int W_PHY2LO_LSB = 0;
	localparam int W_PHY3_LSB = 5;
	localparam int W_DEEMPH_BIT = 12;
	localparam int W_COMPL_BIT = 13;
	localparam int W_DCNT_LSB = 14;
	localparam int W_NOSOFT_BIT = 0;
	localparam int W_AUX_LSB = 1;
	localparam int W_PME_LSB = 6;
	localparam int W_PMDATA_LSB = 8;

	// ==========================================
	// Configuration space offsets and field positions
	localparam logic [7:0] CFG_PMCAP = 8'h40;
	localparam logic [7:0] CFG_PMCSR = 8'h44;
	localparam logic [7:0] CFG_LINKCTL = 8'h68;
	localparam logic [7:0] CFG_PHYCTL = 8'h78;
	localparam logic [7:0] CFG_PHY2 = 8'h7C;
	localparam logic [7:0] CFG_MISC = 8'h8C;
	localparam logic [7:0] CFG_PHY3 = 8'h90;
	localparam logic [7:0] CFG_DEEMPH = 8'hF0;
	localparam int C_FTS_LSB = 0;
	localparam int C_DESKEW_LSB = 13;
	localparam int C_SCRAM_LSB = 8;
	localparam int C_L0S_BIT = 10;
	localparam int C_COMPL_BIT = 11;
	localparam int C_SPDSEL_LSB = 12;
	localparam int C_SPDEN_BIT = 14;
	localparam int C_PHY2HI_LSB = 16;
	localparam int C_PHY2LO_LSB = 8;
	localparam int C_PHY3_LSB = 0;
	localparam int C_DEEMPH_BIT = 6;
	localparam int C_DCNT_LSB = 8;
	localparam int C_NOSOFT_BIT = 3;
	localparam int C_PMDATA_LSB = 24;
	localparam int C_AUX_LSB = 22;
	localparam int C_D1_BIT = 25;
	localparam int C_D2_BIT = 26;
	localparam int C_PME_LSB = 28;

	// ==========================================
	// Register bus map
	localparam logic [AXI_ADDR_W-1:0] CTRL_OFS = 12'h000;
	localparam logic [1:0] PORT_WIN_SEL = 2'h1;
	localparam int CTRL_RELOAD_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	localparam int STATUS_ABSENT_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ==========================================
	// Per-port loaded fields
	typedef struct packed {
		logic [7:0] fts;
		logic [1:0] deskew;
		logic [1:0] scram;
		logic l0s;
		logic [1:0] spd_sel;
		logic spd_en;
		logic [14:0] phy2_hi;
		logic [4:0] phy2_lo;
		logic [6:0] phy3;
		logic deemph;
		logic compl;
		logic [1:0] speed_change_data_count_select;
		logic no_soft_reset;
		logic [2:0] aux_current;
		logic [1:0] pme_d1d2;
		logic [7:0] pm_data;
	} port_cfg_t;

	// Built-in values held while no memory contents are loaded.
	localparam port_cfg_t PORT_CFG_DEFAULT = '0;

endpackage
`default_nettype wire

//--- fetch_if.sv
// Word fetch channel between the load sequencer and the memory reader.
`timescale 1ns/1ns
`default_nettype none
interface fetch_if;
	import cfg_loader_pkg::*;
	logic req;
	logic [7:0] addr;
	logic ack;
	logic [WORD_W-1:0] data;
	logic absent;
	modport requester(output req, output addr, input ack, input data, input absent);
	modport server(input req, input addr, output ack, output data, output absent);
endinterface
`default_nettype wire

//--- config_word_fetch.sv
// Reader that fetches one 16-bit word from the configuration memory port.
`timescale 1ns/1ns
`default_nettype none
module config_word_fetch (
	input wire logic clock,
	input wire logic reset,
	fetch_if.server fetch,
	input wire logic mem_present,
	input wire logic mem_ack,
	input wire logic [cfg_loader_pkg::WORD_W-1:0] mem_rdata,
	output logic mem_rd_req,
	output logic [7:0] mem_addr
);
	import cfg_loader_pkg::*;

	// ==========================================
	// Memory request: held until the memory answers with its ack.
	always_ff @(posedge clock) begin
		if (reset) begin
			mem_rd_req <= 1'b0;
			mem_addr <= 8'h00;
		end else if (fetch.req && !mem_rd_req && mem_present) begin
			mem_rd_req <= 1'b1;
			mem_addr <= fetch.addr;
		end else if (mem_rd_req && mem_ack) begin
			mem_rd_req <= 1'b0;
		end
	end

	// ==========================================
	// Answer to the sequencer: one-cycle ack with the word, or absent at once.
	always_ff @(posedge clock) begin
		if (reset) begin
			fetch.ack <= 1'b0;
			fetch.absent <= 1'b0;
			fetch.data <= 16'h0000;
		end else begin
			fetch.ack <= 1'b0;
			if (fetch.req && !mem_rd_req && !mem_present) begin
				fetch.ack <= 1'b1; // No memory fitted: nothing to wait for.
				fetch.absent <= 1'b1;
			end else if (mem_rd_req && mem_ack) begin
				fetch.ack <= 1'b1;
				fetch.absent <= 1'b0;
				fetch.data <= mem_rdata;
			end
		end
	end

endmodule
`default_nettype wire

//--- eeprom_port_config_loader.sv
// Loader that copies configuration memory words into per-port configuration fields.
//
// Contract
// - FTS word bits 7:0 to 78h bits 7:0.
// - FTS word bits 9:8 to 68h bits 14:13.
// - Bits 11:10 scrambler, bit 12 L0s into 78h.
// - Bits 14:13 to 78h speed select 13:12.
// - Bit 15 to 78h speed enable bit 14.
// - Dedicated word bits 14:0 to 7Ch 30:16.
// - PHY word bits 4:0 to 7Ch 12:8.
// - PHY word bits 11:5 to 90h 6:0.
// - PHY word bit 12 to F0h bit 6.
// - PHY word bit 13 to 78h bit 11.
// - PHY word bits 15:14 to 8Ch 9:8.
// - PM word bit 0 to 44h bit 3.
// - PM word bits 3:1 to 40h 24:22.
// - D1 and D2 support read-only as one.
// - PM word bits 7:6 to 40h 29:28.
// - PM word bits 15:8 to 44h 31:24.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module eeprom_port_config_loader (
	input wire logic clock,
	input wire logic reset,
	input wire logic mem_present,
	input wire logic mem_ack,
	input wire logic [cfg_loader_pkg::WORD_W-1:0] mem_rdata,
	output logic mem_rd_req,
	output logic [7:0] mem_addr,
	output logic load_done,
	input wire logic [cfg_loader_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [cfg_loader_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	import cfg_loader_pkg::*;

	typedef enum logic [1:0] {
		ST_START,
		ST_REQ,
		ST_WAIT,
		ST_DONE
	} load_state_t;

	load_state_t state_q;
	logic [1:0] group_q;
	logic [1:0] port_q;
	logic absent_q;
	logic reload_q;
	logic last_word;
	logic word_taken;
	port_cfg_t cfg_q [NUM_PORTS];
	logic [AXI_ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic write_go;
	logic [33:0] rd_result;
	logic [33:0] wr_result;

	fetch_if fetch ();

	// ==========================================
	// Functions
	// Byte address of the word for one group and port.
	function automatic logic [7:0] word_addr(input logic [1:0] grp, input logic [1:0] port);
		logic [7:0] base;
		base = WORD_LINK_BASE;
		unique case (grp)
			GRP_LINK: base = WORD_LINK_BASE;
			GRP_PHY2: base = WORD_PHY2_BASE;
			GRP_PHY: base = WORD_PHY_BASE;
			GRP_PM: base = WORD_PM_BASE;
		endcase
		return 8'(base + 8'(8'(port) * WORD_STRIDE));
	endfunction

	// Spreads one memory word over the fields of its port.
	function automatic port_cfg_t apply_word(input port_cfg_t c, input logic [1:0] grp,
		input logic [WORD_W-1:0] w);
		port_cfg_t r;
		r = c;
		unique case (grp)
			GRP_LINK: begin
				r.fts = w[W_FTS_LSB +: 8];
				r.deskew = w[W_DESKEW_LSB +: 2];
				r.scram = w[W_SCRAM_LSB +: 2];
				r.l0s = w[W_L0S_BIT];
				r.spd_sel = w[W_SPDSEL_LSB +: 2];
				r.spd_en = w[W_SPDEN_BIT];
			end
			GRP_PHY2: begin
				r.phy2_hi = w[W_PHY2HI_LSB +: 15];
			end
			GRP_PHY: begin
				r.phy2_lo = w[W_PHY2LO_LSB +: 5];
				r.phy3 = w[W_PHY3_LSB +: 7];
				r.deemph = w[W_DEEMPH_BIT];
				r.compl = w[W_COMPL_BIT];
				r.speed_change_data_count_select = w[W_DCNT_LSB +: 2];
			end
			GRP_PM: begin
				r.no_soft_reset = w[W_NOSOFT_BIT];
				r.aux_current = w[W_AUX_LSB +: 3];
				r.pme_d1d2 = w[W_PME_LSB +: 2];
				r.pm_data = w[W_PMDATA_LSB +: 8];
			end
		endcase
		return r;
	endfunction

	// Builds the 32-bit view of one configuration offset; top bit flags a hit.
	function automatic logic [32:0] cfg_view(input port_cfg_t c, input logic [7:0] ofs);
		logic [31:0] v;
		logic hit;
		v = 32'h0000_0000;
		hit = 1'b1;
		case (ofs)
			CFG_PMCAP: begin
				v[C_AUX_LSB +: 3] = c.aux_current;
				v[C_D1_BIT] = 1'b1;
				v[C_D2_BIT] = 1'b1;
				v[C_PME_LSB +: 2] = c.pme_d1d2;
			end
			CFG_PMCSR: begin
				v[C_NOSOFT_BIT] = c.no_soft_reset;
				v[C_PMDATA_LSB +: 8] = c.pm_data;
			end
			CFG_LINKCTL: v[C_DESKEW_LSB +: 2] = c.deskew;
			CFG_PHYCTL: begin
				v[C_FTS_LSB +: 8] = c.fts;
				v[C_SCRAM_LSB +: 2] = c.scram;
				v[C_L0S_BIT] = c.l0s;
				v[C_COMPL_BIT] = c.compl;
				v[C_SPDSEL_LSB +: 2] = c.spd_sel;
				v[C_SPDEN_BIT] = c.spd_en;
			end
			CFG_PHY2: begin
				v[C_PHY2HI_LSB +: 15] = c.phy2_hi;
				v[C_PHY2LO_LSB +: 5] = c.phy2_lo;
			end
			CFG_MISC: v[C_DCNT_LSB +: 2] = c.speed_change_data_count_select;
			CFG_PHY3: v[C_PHY3_LSB +: 7] = c.phy3;
			CFG_DEEMPH: v[C_DEEMPH_BIT] = c.deemph;
			default: hit = 1'b0;
		endcase
		return {hit, v};
	endfunction

	// Decodes a bus address into {response, data}.
	function automatic logic [33:0] bus_read(input logic [AXI_ADDR_W-1:0] a, input logic done,
		input logic absent, input port_cfg_t c);
		logic [32:0] view;
		logic [31:0] d;
		d = 32'h0000_0000;
		view = cfg_view(c, {a[7:2], 2'b00});
		if (a == CTRL_OFS) begin
			d[STATUS_DONE_BIT] = done;
			d[STATUS_ABSENT_BIT] = absent;
			return {RESP_OKAY, d};
		end else if (a[11:10] == PORT_WIN_SEL && view[32]) begin
			return {RESP_OKAY, view[31:0]};
		end
		return {RESP_DECERR, d};
	endfunction

	// ==========================================
	// Memory reader
	config_word_fetch u_fetch (
		.clock(clock),
		.reset(reset),
		.fetch(fetch),
		.mem_present(mem_present),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata),
		.mem_rd_req(mem_rd_req),
		.mem_addr(mem_addr)
	);

	// Request a word for one cycle per step; the address follows the counters.
	assign fetch.req = (state_q == ST_REQ);
	assign fetch.addr = word_addr(group_q, port_q);
	assign word_taken = (state_q == ST_WAIT) && fetch.ack;
	assign last_word = (group_q == GRP_PM) && (port_q == 2'(NUM_PORTS - 1));

	// ==========================================
	// Load sequencer
	// Walks all groups for all ports; a missing memory ends the walk at once.
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= ST_START;
			group_q <= GRP_LINK;
			port_q <= 2'h0;
		end else begin
			unique case (state_q)
				ST_START: begin
					group_q <= GRP_LINK;
					port_q <= 2'h0;
					state_q <= ST_REQ;
				end
				ST_REQ: state_q <= ST_WAIT;
				ST_WAIT: begin
					if (word_taken) begin
						if (fetch.absent || last_word) begin
							state_q <= ST_DONE;
						end else begin
							port_q <= 2'(port_q + 2'h1);
							if (port_q == 2'(NUM_PORTS - 1)) begin
								group_q <= 2'(group_q + 2'h1);
							end
							state_q <= ST_REQ;
						end
					end
				end
				ST_DONE: begin
					if (reload_q) begin
						state_q <= ST_START;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Field store
	// Defaults are restored at each start so a missing memory leaves them in place.
	always_ff @(posedge clock) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				cfg_q[i] <= PORT_CFG_DEFAULT;
			end
		end else if (state_q == ST_START) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				cfg_q[i] <= PORT_CFG_DEFAULT;
			end
		end else if (word_taken && !fetch.absent) begin
			cfg_q[port_q] <= apply_word(cfg_q[port_q], group_q, fetch.data);
		end
	end

	// ==========================================
	// Completion and presence flags
	// Ports may train only once load_done is high.
	always_ff @(posedge clock) begin
		if (reset) begin
			load_done <= 1'b0;
			absent_q <= 1'b0;
		end else if (state_q == ST_START) begin
			load_done <= 1'b0;
			absent_q <= 1'b0;
		end else if (word_taken && (fetch.absent || last_word)) begin
			load_done <= 1'b1;
			absent_q <= fetch.absent;
		end
	end

	// ==========================================
	// Register bus: write channel
	// Address and data are taken in either order; the write acts once both are held.
	assign write_go = !awready && !wready && !bvalid;
	assign wr_result = bus_read(awaddr_q, load_done, absent_q, cfg_q[awaddr_q[9:8]]);

	always_ff @(posedge clock) begin
		if (reset) begin
			awready <= 1'b1;
			awaddr_q <= '0;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			awaddr_q <= awaddr;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	// Write data holding register.
	always_ff @(posedge clock) begin
		if (reset) begin
			wready <= 1'b1;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	// Response; loaded fields are read-only, so writes there are accepted and dropped.
	always_ff @(posedge clock) begin
		if (reset) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (write_go) begin
			bvalid <= 1'b1;
			bresp <= wr_result[33:32];
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// Reload strobe from the control register.
	always_ff @(posedge clock) begin
		if (reset) begin
			reload_q <= 1'b0;
		end else begin
			reload_q <= write_go && (awaddr_q == CTRL_OFS) && wstrb_q[0]
				&& wdata_q[CTRL_RELOAD_BIT];
		end
	end

	// ==========================================
	// Register bus: read channel
	// Reads are held off while a load is running so no stale field is seen.
	assign rd_result = bus_read(araddr, load_done, absent_q, cfg_q[araddr[9:8]]);

	always_ff @(posedge clock) begin
		if (reset) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_result[31:0];
			rresp <= rd_result[33:32];
		end else begin
			arready <= load_done && !rvalid && (state_q == ST_DONE) && !reload_q;
			if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

//--- eeprom_port_config_loader_asserts.sv
// Concurrent checks on the ports of the port configuration loader.
`timescale 1ns/1ns
`default_nettype none
module eeprom_port_config_loader_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic mem_present,
	input wire logic mem_ack,
	input wire logic [cfg_loader_pkg::WORD_W-1:0] mem_rdata,
	input wire logic mem_rd_req,
	input wire logic [7:0] mem_addr,
	input wire logic load_done,
	input wire logic [cfg_loader_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [cfg_loader_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready
);
	import cfg_loader_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// ==========================================
	// Memory port
	// A pending read keeps its address until the memory answers.
	property p_req_hold; mem_rd_req && !mem_ack |=> mem_rd_req && $stable(mem_addr); endproperty
	a_req_hold: assert property (p_req_hold) else $error("read request dropped early");
	property p_req_drop; mem_rd_req && mem_ack |=> !mem_rd_req ##1 !mem_rd_req; endproperty
	a_req_drop: assert property (p_req_drop) else $error("request not released");
	property p_addr_map;
		mem_rd_req |-> !mem_addr[0] && !mem_addr[3] && mem_addr[7:4] >= 4'h2 && mem_addr[7:4] <= 4'h5;
	endproperty
	a_addr_map: assert property (p_addr_map) else $error("unmapped word fetched");
	// Completion follows the memory's answer to the last power word by two cycles.
	property p_done_last;
		$rose(load_done) && mem_present |-> $past(mem_ack, 2) && $past(mem_addr, 2) == 8'h56;
	endproperty
	a_done_last: assert property (p_done_last) else $error("done not after last word");
	property p_idle_done; load_done |-> !mem_rd_req; endproperty
	a_idle_done: assert property (p_idle_done) else $error("fetch after done");
	property p_absent; !mem_present && !$past(mem_present) |-> !$rose(mem_rd_req); endproperty
	a_absent: assert property (p_absent) else $error("fetch with no memory");
	// ==========================================
	// Register bus
	property p_ar_wait; !load_done |-> !arready; endproperty
	a_ar_wait: assert property (p_ar_wait) else $error("read taken during load");
	property p_r_next; arvalid && arready |=> rvalid; endproperty
	a_r_next: assert property (p_r_next) else $error("read answer late");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer unstable");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer unstable");
	property p_b_next;
		awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid;
	endproperty
	a_b_next: assert property (p_b_next) else $error("write answer timing");
	c_load: cover property ($rose(load_done) && mem_present);
	c_absent: cover property ($rose(load_done) && !mem_present);
	c_rerr: cover property (rvalid && rresp == RESP_DECERR);
	c_werr: cover property (bvalid && bresp == RESP_DECERR);
endmodule
`default_nettype wire

//--- cfg_mem_model.sv
// Word port model of the configuration memory, with a prompt and a slow answer.
`timescale 1ns/1ns
`default_nettype none
module cfg_mem_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic slow,
	input wire logic mem_rd_req,
	input wire logic [7:0] mem_addr,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [2:0] wait_q;
	logic [15:0] last_q;
	// Each word mixes its address into its bits; spd_en, compl and speed_change_data_count_select only ever see 0.
	function automatic logic [15:0] word(input logic [7:0] a);
		return {a ^ 8'h5A, (a >> 1) ^ 8'h96};
	endfunction
	// Answer after one or five cycles, for a single cycle.
	always_ff @(posedge clock) begin
		if (reset || !mem_rd_req || mem_ack) begin
			wait_q <= 3'h0;
			mem_ack <= 1'b0;
		end else if (wait_q == (slow ? 3'h4 : 3'h0)) begin
			mem_ack <= 1'b1;
		end else begin
			wait_q <= wait_q + 3'h1;
		end
	end
	// Outside an answer the data lines show the inverse of the last word.
	always_ff @(posedge clock) begin
		if (mem_ack) begin
			last_q <= mem_rdata;
		end
	end
	assign mem_rdata = mem_ack ? word(mem_addr) : ~last_q;
endmodule
`default_nettype wire

//--- tb_eeprom_port_config_loader.sv
// Self-checking bench for the port configuration loader.
`timescale 1ns/1ns
`default_nettype none
module tb_eeprom_port_config_loader;
	import cfg_loader_pkg::*;
	logic clock, reset, mem_present, mem_ack, mem_rd_req, load_done, slow;
	logic [WORD_W-1:0] mem_rdata;
	logic [7:0] mem_addr;
	logic [AXI_ADDR_W-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	// When set, bready and rready rise only once the answer is seen, so answers must stand.
	logic lag_ready = 1'b0;
	eeprom_port_config_loader u_dut (.*);
	cfg_mem_model u_mem (.*);
	always #5 clock = ~clock;
	// ==========================================
	// Checking and verdict
	task automatic stop_test;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// The whole run needs well under this many cycles.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	// ==========================================
	// Register bus master
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= !lag_ready;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && !bready) bready <= 1'b1;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clock);
	endtask
	task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !lag_ready;
		do begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && !rready) rready <= 1'b1;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		chk("rdata", ed, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge clock);
	endtask
	// ==========================================
	// Expected port fields
	function automatic logic [15:0] word(input logic [7:0] a);
		return {a ^ 8'h5A, (a >> 1) ^ 8'h96};
	endfunction
	function automatic logic [31:0] exp_cfg(input int p, input logic [7:0] o, input logic ld);
		logic [15:0] l, h, y, m;
		logic [7:0] s;
		s = 8'(2 * p);
		l = ld ? word(WORD_LINK_BASE + s) : 16'h0;
		h = ld ? word(WORD_PHY2_BASE + s) : 16'h0;
		y = ld ? word(WORD_PHY_BASE + s) : 16'h0;
		m = ld ? word(WORD_PM_BASE + s) : 16'h0;
		case (o)
			CFG_PMCAP: return {2'h0, m[7:6], 1'b0, 2'h3, m[3:1], 22'h0};
			CFG_PMCSR: return {m[15:8], 20'h0, m[0], 3'h0};
			CFG_LINKCTL: return {17'h0, l[9:8], 13'h0};
			CFG_PHYCTL: return {17'h0, l[15], l[14:13], y[13], l[12], l[11:10], l[7:0]};
			CFG_PHY2: return {1'b0, h[14:0], 3'h0, y[4:0], 8'h0};
			CFG_MISC: return {22'h0, y[15:14], 8'h0};
			CFG_PHY3: return {25'h0, y[11:5]};
			default: return {25'h0, y[12], 6'h0};
		endcase
	endfunction
	// Reads every mapped offset of all four port windows.
	task automatic check_ports(input logic ld);
		logic [11:0] b;
		for (int p = 0; p < NUM_PORTS; p++) begin
			b = 12'h400 + 12'(p) * 12'h100;
			axi_read(b + 12'(CFG_PMCAP), exp_cfg(p, CFG_PMCAP, ld), RESP_OKAY);
			axi_read(b + 12'(CFG_PMCSR), exp_cfg(p, CFG_PMCSR, ld), RESP_OKAY);
			axi_read(b + 12'(CFG_LINKCTL), exp_cfg(p, CFG_LINKCTL, ld), RESP_OKAY);
			axi_read(b + 12'(CFG_PHYCTL), exp_cfg(p, CFG_PHYCTL, ld), RESP_OKAY);
			axi_read(b + 12'(CFG_PHY2), exp_cfg(p, CFG_PHY2, ld), RESP_OKAY);
			axi_read(b + 12'(CFG_MISC), exp_cfg(p, CFG_MISC, ld), RESP_OKAY);
			axi_read(b + 12'(CFG_PHY3), exp_cfg(p, CFG_PHY3, ld), RESP_OKAY);
			axi_read(b + 12'(CFG_DEEMPH), exp_cfg(p, CFG_DEEMPH, ld), RESP_OKAY);
		end
	endtask
	// ==========================================
	// Main sequence
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		mem_present = 1'b1;
		slow = 1'b0;
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = '0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		// A status read offered during the load is answered only once it is over.
		axi_read(CTRL_OFS, 32'h2, RESP_OKAY);
		check_ports(1'b1);
		// Loaded fields ignore writes; holes in the map are refused; answers wait for ready.
		lag_ready = 1'b1;
		axi_write(12'h478, 32'hFFFFFFFF, RESP_OKAY);
		axi_write(12'h540, 32'hFFFFFFFF, RESP_OKAY);
		axi_read(12'h478, exp_cfg(0, CFG_PHYCTL, 1'b1), RESP_OKAY);
		axi_read(12'h540, exp_cfg(1, CFG_PMCAP, 1'b1), RESP_OKAY);
		axi_write(12'h800, 32'h0, RESP_DECERR);
		axi_read(12'h470, 32'h0, RESP_DECERR);
		lag_ready = 1'b0;
		// Reload with no memory fitted leaves the built-in values.
		mem_present <= 1'b0;
		axi_write(CTRL_OFS, 32'h1, RESP_OKAY);
		axi_read(CTRL_OFS, 32'h6, RESP_OKAY);
		check_ports(1'b0);
		// Reload from a slow memory restores every field.
		mem_present <= 1'b1;
		slow <= 1'b1;
		axi_write(CTRL_OFS, 32'h1, RESP_OKAY);
		axi_read(CTRL_OFS, 32'h2, RESP_OKAY);
		check_ports(1'b1);
		stop_test();
	end
endmodule
bind eeprom_port_config_loader eeprom_port_config_loader_asserts u_chk (.*);
`default_nettype wire
